//--- rtl/pac_pkg.sv
// Constants and types shared by the positioner axis control word decoder.
package pac_pkg;

  typedef enum logic [1:0] {
    PAC_UNIT_WORD = 2'h0,
    PAC_UNIT_BYTE = 2'h1,
    PAC_UNIT_MODULE = 2'h2
  } pac_unit_t;

  localparam logic [15:0] PAC_HEAD_ADDR_DEF = 16'h0000;
  localparam logic [1:0] PAC_POS_WORD = 2'h0;
  localparam logic [1:0] PAC_CTRL_WORD = 2'h1;
  localparam logic [15:0] PAC_POS_RST = 16'h0000;
  localparam logic [15:0] PAC_CTRL_RST = 16'h0000;
  localparam logic [15:0] PAC_POS_MASK = 16'h007f;
  localparam logic [15:0] PAC_CTRL_MASK = 16'h877f;
  localparam logic [6:0] PAC_DONE_POS_RST = 7'h00;

  typedef struct packed {
    logic brake_force_release;
    logic [3:0] unassigned;
    logic teach_mode;
    logic position_import_cmd;
    logic jog_away_home;
    logic unassigned_b7;
    logic jog_param_set_select;
    logic inching_select;
    logic servo_enable;
    logic fault_reset_cmd;
    logic pause_cmd;
    logic home_cmd;
    logic move_start_cmd;
  } pac_ctrl_t;

  typedef struct packed {
    logic [4:0] other_hi;
    logic teach_mode_status;
    logic import_done_flag;
    logic [1:0] other_mid;
    logic [6:0] completed_position_number;
  } pac_status_t;

  typedef enum logic [2:0] {
    PAC_IDLE = 3'h1,
    PAC_HOMING = 3'h2,
    PAC_MOVING = 3'h4
  } pac_state_t;

endpackage

//--- rtl/pac_axis_ctrl.sv
// Decoder of one axis's cyclic control image in positioner modes 1 and 2.
module pac_axis_ctrl #(
  parameter pac_pkg::pac_unit_t ADDR_UNIT = pac_pkg::PAC_UNIT_WORD,
  parameter logic [15:0] HEAD_ADDR = pac_pkg::PAC_HEAD_ADDR_DEF
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_addr,
  input wire logic [1:0] i_wr_sub,
  input wire logic [15:0] i_wr_data,
  input wire logic i_home_done,
  input wire logic i_move_done,
  input wire logic i_import_done,
  input wire logic i_alarm,
  input wire logic [6:0] i_alarm_code,
  output logic o_brake_force_release,
  output logic o_teach_mode,
  output logic o_position_import,
  output logic o_jog_away_home,
  output logic o_jog_param_set_select,
  output logic o_inching_select,
  output logic o_servo_enable,
  output logic o_fault_reset,
  output logic o_pause_cmd,
  output logic o_home_start,
  output logic o_move_start,
  output logic o_homing_busy,
  output logic o_moving_busy,
  output logic [6:0] o_target_position_number,
  output pac_pkg::pac_status_t o_status_word
);

  // ****************************************
  // Address decode
  // ****************************************
  logic [15:0] rel_addr;
  logic [1:0] word_sel;
  logic addr_hit;
  logic wr_pos;
  logic wr_ctrl;

  assign rel_addr = i_wr_addr - HEAD_ADDR;
  // Byte units need an even address; a module spans four words picked by i_wr_sub.
  assign word_sel = (ADDR_UNIT == pac_pkg::PAC_UNIT_MODULE) ? i_wr_sub :
                    (ADDR_UNIT == pac_pkg::PAC_UNIT_BYTE) ? rel_addr[2:1] : rel_addr[1:0];
  assign addr_hit = (ADDR_UNIT == pac_pkg::PAC_UNIT_MODULE) ? (rel_addr == 16'h0000) :
                    (ADDR_UNIT == pac_pkg::PAC_UNIT_BYTE) ? (rel_addr[15:3] == 13'h0000 && !rel_addr[0]) :
                    (rel_addr[15:2] == 14'h0000);
  assign wr_pos = i_wr_en & addr_hit & (word_sel == pac_pkg::PAC_POS_WORD);
  assign wr_ctrl = i_wr_en & addr_hit & (word_sel == pac_pkg::PAC_CTRL_WORD);

  // ****************************************
  // Image registers
  // ****************************************
  logic [15:0] axis_command_position;
  pac_pkg::pac_ctrl_t axis_control_word;
  pac_pkg::pac_ctrl_t ctrl_q;

  // Unassigned bits are masked off on write so they can steer nothing.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      axis_command_position <= pac_pkg::PAC_POS_RST;
      axis_control_word <= pac_pkg::PAC_CTRL_RST;
      ctrl_q <= pac_pkg::PAC_CTRL_RST;
    end else begin
      if (wr_pos) begin
        axis_command_position <= i_wr_data & pac_pkg::PAC_POS_MASK;
      end
      if (wr_ctrl) begin
        axis_control_word <= i_wr_data & pac_pkg::PAC_CTRL_MASK;
      end
      ctrl_q <= axis_control_word;
    end
  end

  // ****************************************
  // Edge detection and sequencing
  // ****************************************
  logic home_rise;
  logic move_rise;
  logic reset_rise;
  logic import_rise;
  logic home_go;
  logic move_go;
  logic import_go;
  pac_pkg::pac_state_t state;
  pac_pkg::pac_state_t next_state;

  assign home_rise = axis_control_word.home_cmd & ~ctrl_q.home_cmd;
  assign move_rise = axis_control_word.move_start_cmd & ~ctrl_q.move_start_cmd;
  assign reset_rise = axis_control_word.fault_reset_cmd & ~ctrl_q.fault_reset_cmd;
  assign import_rise = axis_control_word.position_import_cmd & ~ctrl_q.position_import_cmd;
  // Homing wins when both edges land together; no start is taken during an alarm.
  assign home_go = (state == pac_pkg::PAC_IDLE) & ~i_alarm & home_rise;
  assign move_go = (state == pac_pkg::PAC_IDLE) & ~i_alarm & ~home_rise & move_rise;
  assign import_go = import_rise & axis_control_word.teach_mode;

  // A sequence ends only on its done report or an alarm, never on the command bit.
  always_comb begin
    next_state = state;
    case (state)
      pac_pkg::PAC_IDLE: begin
        if (home_go) begin
          next_state = pac_pkg::PAC_HOMING;
        end else if (move_go) begin
          next_state = pac_pkg::PAC_MOVING;
        end
      end
      pac_pkg::PAC_HOMING: begin
        if (i_home_done | i_alarm) begin
          next_state = pac_pkg::PAC_IDLE;
        end
      end
      pac_pkg::PAC_MOVING: begin
        if (i_move_done | i_alarm) begin
          next_state = pac_pkg::PAC_IDLE;
        end
      end
      default: begin
        next_state = pac_pkg::PAC_IDLE;
      end
    endcase
  end

  // ****************************************
  // Completed position and import flag
  // ****************************************
  logic [6:0] done_pos;
  logic import_done_flag;
  logic [6:0] next_status_pos;

  assign next_status_pos = i_alarm ? i_alarm_code : done_pos;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= pac_pkg::PAC_IDLE;
      done_pos <= pac_pkg::PAC_DONE_POS_RST;
      import_done_flag <= 1'b0;
    end else begin
      state <= next_state;
      if ((state == pac_pkg::PAC_MOVING) & i_move_done) begin
        done_pos <= o_target_position_number;
      end
      // A finishing import sets the flag even while the command bit is being cleared.
      if (i_import_done) begin
        import_done_flag <= 1'b1;
      end else if (!axis_control_word.position_import_cmd) begin
        import_done_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_brake_force_release <= 1'b0;
      o_teach_mode <= 1'b0;
      o_position_import <= 1'b0;
      o_jog_away_home <= 1'b0;
      o_jog_param_set_select <= 1'b0;
      o_inching_select <= 1'b0;
      o_servo_enable <= 1'b0;
      o_fault_reset <= 1'b0;
      o_pause_cmd <= 1'b0;
      o_home_start <= 1'b0;
      o_move_start <= 1'b0;
      o_homing_busy <= 1'b0;
      o_moving_busy <= 1'b0;
      o_target_position_number <= pac_pkg::PAC_DONE_POS_RST;
      o_status_word <= '0;
    end else begin
      o_brake_force_release <= axis_control_word.brake_force_release;
      o_teach_mode <= axis_control_word.teach_mode;
      o_position_import <= import_go;
      o_jog_away_home <= axis_control_word.jog_away_home;
      o_jog_param_set_select <= axis_control_word.jog_param_set_select;
      o_inching_select <= axis_control_word.inching_select;
      o_servo_enable <= axis_control_word.servo_enable;
      o_fault_reset <= reset_rise;
      o_pause_cmd <= axis_control_word.pause_cmd;
      o_home_start <= home_go;
      o_move_start <= move_go;
      o_homing_busy <= (next_state == pac_pkg::PAC_HOMING);
      o_moving_busy <= (next_state == pac_pkg::PAC_MOVING);
      if (move_go) begin
        o_target_position_number <= axis_command_position[6:0];
      end
      o_status_word.completed_position_number <= next_status_pos;
      o_status_word.import_done_flag <= import_done_flag;
      o_status_word.teach_mode_status <= axis_control_word.teach_mode;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  brake_follow_a: assert property (wr_ctrl |-> ##2 o_brake_force_release == $past(i_wr_data[15], 2))
    else $error("Brake release does not follow control bit 15.");
  teach_follow_a: assert property (wr_ctrl |-> ##2 o_teach_mode == $past(i_wr_data[10], 2))
    else $error("Teaching mode does not follow control bit 10.");
  import_teach_a: assert property (o_position_import |-> $past(axis_control_word.teach_mode))
    else $error("Position import issued outside teaching mode.");
  jog_follow_a: assert property (wr_ctrl |-> ##2 o_jog_away_home == $past(i_wr_data[8], 2))
    else $error("Jog output does not follow control bit 8.");
  property manual_sel_p;
    wr_ctrl |-> ##2 {o_jog_param_set_select, o_inching_select} == $past(i_wr_data[6:5], 2);
  endproperty
  manual_sel_a: assert property (manual_sel_p)
    else $error("Jog parameter or inching selection wrong.");
  property servo_pause_p;
    wr_ctrl |-> ##2 {o_servo_enable, o_pause_cmd} == $past({i_wr_data[4], i_wr_data[2]}, 2);
  endproperty
  servo_pause_a: assert property (servo_pause_p)
    else $error("Servo enable or pause does not follow control word.");
  fault_pulse_a: assert property ($rose(axis_control_word.fault_reset_cmd) |=> o_fault_reset ##1 !o_fault_reset)
    else $error("Fault reset pulse missing or too long.");
  property home_hold_p;
    state == pac_pkg::PAC_HOMING && !i_home_done && !i_alarm |=> state == pac_pkg::PAC_HOMING;
  endproperty
  home_hold_a: assert property (home_hold_p)
    else $error("Homing ended before completion.");
  property move_hold_p;
    state == pac_pkg::PAC_MOVING && !i_move_done && !i_alarm |=> o_moving_busy;
  endproperty
  move_hold_a: assert property (move_hold_p)
    else $error("Travel ended before completion.");
  unused_bits_a: assert property ((axis_control_word & ~pac_pkg::PAC_CTRL_MASK) == 16'h0000)
    else $error("Unassigned control bits were stored.");
  alarm_code_a: assert property (i_alarm |=> o_status_word.completed_position_number == $past(i_alarm_code))
    else $error("Alarm code not reported in status field.");
  import_done_a: assert property (i_import_done |-> ##2 o_status_word.import_done_flag)
    else $error("Import done flag not set.");
  property start_sample_p;
    o_move_start |-> o_target_position_number == $past(axis_command_position[6:0]) && $past(move_rise);
  endproperty
  start_sample_a: assert property (start_sample_p)
    else $error("Target not sampled at the start edge.");

  // ****************************************
  // Sequencing and status assertions
  // ****************************************
  property home_start_busy_p;
    o_home_start |-> o_homing_busy && $past(home_rise);
  endproperty
  home_start_busy_a: assert property (home_start_busy_p)
    else $error("Homing start pulse without a running homing sequence.");

  property move_start_busy_p;
    o_move_start |-> o_moving_busy;
  endproperty
  move_start_busy_a: assert property (move_start_busy_p)
    else $error("Travel start pulse without a running travel.");

  property alarm_start_block_p;
    i_alarm |=> !o_home_start && !o_move_start;
  endproperty
  alarm_start_block_a: assert property (alarm_start_block_p)
    else $error("A sequence was started during an alarm.");

  property alarm_abort_p;
    state != pac_pkg::PAC_IDLE && i_alarm |=> state == pac_pkg::PAC_IDLE;
  endproperty
  alarm_abort_a: assert property (alarm_abort_p)
    else $error("A running sequence was not aborted by an alarm.");

  property done_pos_latch_p;
    state == pac_pkg::PAC_MOVING && i_move_done |=> done_pos == $past(o_target_position_number);
  endproperty
  done_pos_latch_a: assert property (done_pos_latch_p)
    else $error("Completed position not taken from the travel target.");

  property status_pos_p;
    !i_alarm |=> o_status_word.completed_position_number == $past(done_pos);
  endproperty
  status_pos_a: assert property (status_pos_p)
    else $error("Status field does not show the completed position.");

  property import_clear_p;
    !axis_control_word.position_import_cmd && !i_import_done |=> !import_done_flag;
  endproperty
  import_clear_a: assert property (import_clear_p)
    else $error("Import done flag not cleared with the import command.");

  property import_issue_p;
    $rose(axis_control_word.position_import_cmd) && axis_control_word.teach_mode |=> o_position_import;
  endproperty
  import_issue_a: assert property (import_issue_p)
    else $error("Position import not issued in teaching mode.");

  property teach_status_p;
    o_status_word.teach_mode_status == $past(axis_control_word.teach_mode);
  endproperty
  teach_status_a: assert property (teach_status_p)
    else $error("Teaching mode status does not follow control bit 10.");

  home_seen_c: cover property (o_home_start ##[1:50] i_home_done);
  move_seen_c: cover property (o_move_start ##1 !axis_control_word.move_start_cmd ##[1:50] i_move_done);
  import_seen_c: cover property (o_position_import ##[1:50] o_status_word.import_done_flag);
  alarm_move_c: cover property (o_moving_busy && i_alarm);
  home_clear_c: cover property (o_homing_busy && !axis_control_word.home_cmd);

endmodule

//--- testbench/pac_core_model.sv
// Behavioural motion core that answers homing, travel and import requests after a delay.
module pac_core_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_home_start,
  input wire logic i_move_start,
  input wire logic i_import,
  output logic o_home_done,
  output logic o_move_done,
  output logic o_import_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [3];
  logic [2:0] go;
  logic [2:0] done;
  assign go = {i_import, i_move_start, i_home_start};
  assign o_home_done = done[0];
  assign o_move_done = done[1];
  assign o_import_done = done[2];
  // Each request runs a countdown; the done pulse is one cycle wide.
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 3; k++) begin
      done[k] <= !i_srst && (cnt[k] == 1);
      if (i_srst) begin
        cnt[k] <= 0;
      end else if (go[k]) begin
        cnt[k] <= i_slow ? 40 : 4;
      end else if (cnt[k] > 0) begin
        cnt[k] <= cnt[k] - 1;
      end
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench of the axis control word decoder.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] HEAD = 16'h0010;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic wr_en = 1'b0;
  logic [15:0] wr_addr = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] wr_sub = 2'h0;
  logic alarm = 1'b0;
  logic slow = 1'b0;
  logic home_done, move_done, import_done;
  logic brake, teach, pimp, jog, jset, inch, servo, freset, pause, hstart, mstart, hbusy, mbusy;
  logic [6:0] target;
  logic [2:1] ubrake;
  pac_pkg::pac_status_t status;
  int err_count = 0;
  int tests_run = 0;
  bit seen;
  logic [15:0] row_in [9] = '{16'h8000, 16'h0400, 16'h0100, 16'h0040, 16'h0020, 16'h0010, 16'h0004,
    16'h7880, 16'h8574};
  logic [6:0] row_out [9] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h00, 7'h7f};
  wire [6:0] lv = {brake, teach, jog, jset, inch, servo, pause};
  wire [4:0] ev = {status.import_done_flag, pimp, freset, hstart, mstart};

  pac_axis_ctrl #(.ADDR_UNIT(pac_pkg::PAC_UNIT_WORD), .HEAD_ADDR(HEAD)) DUT (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_sub(2'h0), .i_wr_data(wr_data), .i_home_done(home_done),
    .i_move_done(move_done), .i_import_done(import_done), .i_alarm(alarm), .i_alarm_code(7'h55),
    .o_brake_force_release(brake), .o_teach_mode(teach), .o_position_import(pimp), .o_jog_away_home(jog),
    .o_jog_param_set_select(jset), .o_inching_select(inch), .o_servo_enable(servo), .o_fault_reset(freset),
    .o_pause_cmd(pause), .o_home_start(hstart), .o_move_start(mstart), .o_homing_busy(hbusy),
    .o_moving_busy(mbusy), .o_target_position_number(target), .o_status_word(status));

  pac_core_model core (.i_mclk(i_mclk), .i_srst(i_srst), .i_slow(slow), .i_home_start(hstart),
    .i_move_start(mstart), .i_import(pimp), .o_home_done(home_done), .o_move_done(move_done),
    .o_import_done(import_done));

  // Byte and module addressed copies, watched through their brake output only.
  for (genvar u = 1; u < 3; u++) begin : g_unit
    pac_axis_ctrl #(.ADDR_UNIT(u == 1 ? pac_pkg::PAC_UNIT_BYTE : pac_pkg::PAC_UNIT_MODULE), .HEAD_ADDR(HEAD)) DUT (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_sub(wr_sub),
      .i_wr_data(wr_data), .i_home_done(1'b0), .i_move_done(1'b0), .i_import_done(1'b0), .i_alarm(1'b0),
      .i_alarm_code(7'h00), .o_brake_force_release(ubrake[u]), .o_teach_mode(), .o_position_import(),
      .o_jog_away_home(), .o_jog_param_set_select(), .o_inching_select(), .o_servo_enable(), .o_fault_reset(),
      .o_pause_cmd(), .o_home_start(), .o_move_start(), .o_homing_busy(), .o_moving_busy(),
      .o_target_position_number(), .o_status_word());
  end

  initial begin
    forever #10 i_mclk = ~i_mclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(input logic [15:0] off, input logic [15:0] d);
    @(negedge i_mclk);
    wr_en = 1'b1;
    wr_addr = HEAD + off;
    wr_data = d;
    @(negedge i_mclk);
    wr_en = 1'b0;
  endtask

  task automatic wait_ev(input int b, input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge i_mclk);
      seen = (ev[b] === 1'b1);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(negedge i_mclk);
    i_srst = 1'b0;
    chk("levels after reset", 16'h0000, {9'h0, lv});
    chk("status after reset", 16'h0000, status);
    $display("reset test done");
    for (int r = 0; r < 9; r++) begin
      wr(16'h0001, row_in[r]);
      repeat (2) @(negedge i_mclk);
      chk("level outputs", {9'h0, row_out[r]}, {9'h0, lv});
    end
    wr(16'h0004, 16'h8000);
    wr(16'h0002, 16'h8000);
    repeat (2) @(negedge i_mclk);
    chk("missed write", {9'h0, row_out[8]}, {9'h0, lv});
    chk("byte unit control word", 16'h0001, {15'h0, ubrake[1]});
    chk("module unit miss", 16'h0000, {15'h0, ubrake[2]});
    $display("level table test done");
    wr(16'h0001, 16'h0010);
    wr(16'h0000, 16'hff2a);
    wr(16'h0001, 16'h0011);
    wait_ev(0, 6);
    chk("move start", 16'h0001, {15'h0, seen});
    wr(16'h0001, 16'h0010);
    wr(16'h0000, 16'h0005);
    chk("moving kept", 16'h0001, {15'h0, mbusy});
    chk("target sampled", 16'h002a, {9'h0, target});
    repeat (8) @(negedge i_mclk);
    chk("completed number", 16'h002a, {9'h0, status.completed_position_number});
    $display("travel test done");
    slow = 1'b1;
    wr(16'h0001, 16'h0012);
    wait_ev(1, 6);
    chk("home start", 16'h0001, {15'h0, seen});
    wr(16'h0001, 16'h0010);
    repeat (20) @(negedge i_mclk);
    chk("homing kept", 16'h0001, {15'h0, hbusy});
    repeat (30) @(negedge i_mclk);
    chk("homing ended", 16'h0000, {15'h0, hbusy});
    $display("homing test done");
    wr(16'h0001, 16'h0018);
    wait_ev(2, 6);
    chk("fault reset", 16'h0001, {15'h0, seen});
    wr(16'h0001, 16'h0200);
    wait_ev(3, 6);
    chk("import refused", 16'h0000, {15'h0, seen});
    wr(16'h0001, 16'h0400);
    wr(16'h0001, 16'h0600);
    wait_ev(3, 6);
    chk("import pulse", 16'h0001, {15'h0, seen});
    wait_ev(4, 60);
    chk("import done", 16'h0001, {15'h0, seen});
    wr(16'h0001, 16'h0400);
    repeat (2) @(negedge i_mclk);
    chk("import flag cleared", 16'h0000, {15'h0, status.import_done_flag});
    chk("teach status", 16'h0001, {15'h0, status.teach_mode_status});
    $display("reset and import test done");
    alarm = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("alarm code", 16'h0055, {9'h0, status.completed_position_number});
    wr(16'h0001, 16'h0401);
    wait_ev(0, 6);
    chk("start refused in alarm", 16'h0000, {15'h0, seen});
    alarm = 1'b0;
    wr(16'h0001, 16'h0400);
    wr(16'h0001, 16'h0401);
    wait_ev(0, 6);
    chk("start after alarm", 16'h0001, {15'h0, seen});
    alarm = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("alarm aborts travel", 16'h0000, {15'h0, mbusy});
    alarm = 1'b0;
    repeat (45) @(negedge i_mclk);
    chk("completed after abort", 16'h002a, {9'h0, status.completed_position_number});
    $display("alarm test done");
    wr_sub = 2'h1;
    wr(16'h0003, 16'h0000);
    wr(16'h0000, 16'h8000);
    repeat (2) @(negedge i_mclk);
    chk("byte odd address", 16'h0001, {15'h0, ubrake[1]});
    chk("module word select", 16'h0001, {15'h0, ubrake[2]});
    $display("address unit test done");
    i_srst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_srst = 1'b0;
    chk("levels after second reset", 16'h0000, {9'h0, lv});
    chk("status after second reset", 16'h0000, status);
    $display("second reset test done");
    results();
  end
endmodule
